// >>> design/debug_trace_control_trigger.sv
// How it works
// - Enable reads zero, unsettable when secured
// - Armed bit gates A/B triggering and capturing; C breaks need no arm
// - Kind bit: force or tag request
// - Break enable gates all break requests
// - Loop filter tracks no loops in event-only modes, still blocks C breaks
// - Repeat change-of-flow address skips FIFO write
// - New address stored and loaded into C
// - End-trace reset, if enabled with end placement, clears only arm, break
// - End-trace reset keeps trigger setup
// - Trigger setup writes ignored while armed
// - Opcode select: access or executed fetch
// - Begin placement starts capture at trigger
// - Codes 0-2: A, A or B, A then B
// - Codes 3-4: event-only B modes
// - Codes 5-6: full A and B modes
// - Range modes; codes 9-15 never trigger
// - Full modes: B compares data byte
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module debug_trace_control_trigger
    import trace_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic end_trace_reset_i,
    input wire logic secure_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire bus_cycle_s bus_i,
    input wire logic [16:0] cmp_a_addr_i,
    input wire logic [16:0] cmp_b_addr_i,
    input wire logic [7:0] comparator_b_low_byte_i,
    input wire logic [16:0] cmp_c_addr_i,
    input wire logic cmp_c_paged_i,
    input wire logic fifo_full_i,
    output fifo_write_s fifo_o,
    output logic load_c_o,
    output logic [16:0] load_c_addr_o,
    output logic load_c_paged_o,
    output logic break_force_o,
    output logic break_tag_o,
    output logic triggered_o
);

    logic [1:0] secure_sync_q;
    logic secure;
    logic soft_rst_q;
    logic soft_rst_d;
    logic [7:0] ctrl_q;
    logic [7:0] trig_q;
    logic module_enable;
    logic capture_armed;
    logic breakpoint_kind_select;
    logic cpu_break_enable;
    logic repeat_loop_filter;
    logic opcode_trigger_select;
    logic trigger_position_select;
    logic [3:0] trigger_mode_code;
    logic wr;
    logic rd_hit;
    logic qual;
    logic match_a;
    logic match_b;
    logic match_c;
    logic event_only;
    logic full_mode;
    logic trig_hit;
    logic in_range;
    logic loop_active;
    logic store_flow;
    logic store_event;
    logic run_end;
    logic end_trace_held_q;
    run_state_e state_q;
    run_state_e state_d;
    fifo_write_s loop_fifo;

    assign module_enable = ctrl_q[CTRL_EN_BIT] && !secure;
    assign capture_armed = ctrl_q[CTRL_ARM_BIT];
    assign breakpoint_kind_select = ctrl_q[CTRL_TAG_BIT];
    assign cpu_break_enable = ctrl_q[CTRL_BRK_BIT];
    assign repeat_loop_filter = ctrl_q[CTRL_LOOP_BIT];
    assign opcode_trigger_select = trig_q[TRIG_OPC_BIT];
    assign trigger_position_select = trig_q[TRIG_BEGIN_BIT];
    assign trigger_mode_code = trig_q[TRIG_MODE_LSB +: 4];

    // Security arrives from another block's domain
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            // Starts unsecured so the enable keeps its reset value
            secure_sync_q <= 2'b00;
        end
        else
        begin
            secure_sync_q <= {secure_sync_q[0], secure_i};
        end
    end

    assign secure = secure_sync_q[1];

    // Reset cause is sampled clocked; an async clear cannot keep field values
    assign soft_rst_d = end_trace_reset_i && module_enable && !trigger_position_select;

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            soft_rst_q <= 1'b0;
        end
        else
        begin
            soft_rst_q <= soft_rst_d;
        end
    end

    assign wr = psel_i && penable_i && pwrite_i;
    assign pready_o = 1'b1;

    // Control register
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            ctrl_q <= CTRL_RESET;
        end
        else if (soft_rst_q)
        begin
            ctrl_q[CTRL_ARM_BIT] <= 1'b0;
            ctrl_q[CTRL_BRK_BIT] <= 1'b0;
        end
        else
        begin
            if (wr && paddr_i == CTRL_ADDR)
            begin
                ctrl_q <= pwdata_i[7:0] & CTRL_WMASK;
                ctrl_q[CTRL_EN_BIT] <= pwdata_i[CTRL_EN_BIT] && !secure;
            end
            else if (run_end)
            begin
                ctrl_q[CTRL_ARM_BIT] <= 1'b0;
            end
            if (secure)
            begin
                ctrl_q[CTRL_EN_BIT] <= 1'b0;
            end
        end
    end

    // Trigger setup register; untouched by end-trace reset
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            trig_q <= TRIG_RESET;
        end
        else if (wr && paddr_i == TRIG_ADDR && !capture_armed && !soft_rst_q)
        begin
            trig_q <= pwdata_i[7:0] & TRIG_WMASK;
        end
    end

    // Read side
    always_comb
    begin
        rd_hit = 1'b1;
        prdata_o = 32'h0000_0000;
        case (paddr_i)
            CTRL_ADDR:
            begin
                prdata_o[7:0] = ctrl_q;
                prdata_o[CTRL_EN_BIT] = module_enable;
            end
            TRIG_ADDR:
            begin
                prdata_o[7:0] = trig_q;
            end
            STAT_ADDR:
            begin
                prdata_o[2:0] = {triggered_o, state_q};
            end
            default:
            begin
                rd_hit = 1'b0;
            end
        endcase
    end

    assign pslverr_o = psel_i && penable_i && !rd_hit;

    // Comparators; opcode qualifier chooses access or executed fetch
    assign qual = bus_i.valid && (!opcode_trigger_select || bus_i.executed);
    assign full_mode = trigger_mode_code == MODE_A_AND_B || trigger_mode_code == MODE_A_AND_NOT_B;
    assign match_a = qual && bus_i.addr == cmp_a_addr_i;
    // Full modes compare B against the data bus low byte
    assign match_b = full_mode ? (qual && bus_i.data == comparator_b_low_byte_i)
                               : (qual && bus_i.addr == cmp_b_addr_i);
    assign match_c = qual && bus_i.addr == cmp_c_addr_i;
    assign in_range = bus_i.addr >= cmp_a_addr_i && bus_i.addr <= cmp_b_addr_i;
    assign event_only = trigger_mode_code == MODE_EVENT_B ||
                        trigger_mode_code == MODE_A_THEN_EVENT_B;

    always_comb
    begin
        case (trigger_mode_code)
            MODE_A_ONLY: trig_hit = match_a;
            MODE_A_OR_B: trig_hit = match_a || match_b;
            MODE_A_THEN_B: trig_hit = (state_q == RUN_CAPTURE) ? match_b : 1'b0;
            MODE_EVENT_B: trig_hit = match_b;
            MODE_A_THEN_EVENT_B: trig_hit = match_a;
            MODE_A_AND_B: trig_hit = match_a && match_b;
            MODE_A_AND_NOT_B: trig_hit = match_a && !match_b;
            MODE_INSIDE: trig_hit = qual && in_range;
            MODE_OUTSIDE: trig_hit = qual && !in_range;
            default: trig_hit = 1'b0;
        endcase
    end

    // Run sequencer: WAIT_A is the first half of the two-step modes
    always_comb
    begin
        state_d = state_q;
        run_end = 1'b0;
        case (state_q)
            RUN_IDLE:
            begin
                if (module_enable && capture_armed)
                begin
                    if (trigger_mode_code == MODE_A_THEN_B ||
                        trigger_mode_code == MODE_A_THEN_EVENT_B)
                    begin
                        state_d = RUN_WAIT_A;
                    end
                    else
                    begin
                        state_d = RUN_CAPTURE;
                    end
                end
            end
            RUN_WAIT_A:
            begin
                if (match_a)
                begin
                    state_d = RUN_CAPTURE;
                end
            end
            RUN_CAPTURE:
            begin
                if (trigger_position_select)
                begin
                    run_end = fifo_full_i;
                end
                else
                begin
                    run_end = trig_hit && !event_only;
                end
                if (run_end)
                begin
                    state_d = RUN_IDLE;
                end
            end
            default:
            begin
                state_d = RUN_IDLE;
            end
        endcase
        if (!(module_enable && capture_armed))
        begin
            state_d = RUN_IDLE;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            state_q <= RUN_IDLE;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // Begin placement: storing starts once the trigger has fired
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            triggered_o <= 1'b0;
        end
        else if (state_q == RUN_IDLE)
        begin
            triggered_o <= 1'b0;
        end
        else if (state_q == RUN_CAPTURE && trig_hit)
        begin
            triggered_o <= 1'b1;
        end
    end

    assign store_flow = state_q == RUN_CAPTURE && !event_only && bus_i.valid &&
                        bus_i.flow_change &&
                       (!trigger_position_select || triggered_o);
    assign store_event = state_q == RUN_CAPTURE && event_only && match_b;
    assign loop_active = repeat_loop_filter && !event_only;

    trace_loop_track loop_track (
        .clk_i(clk_i),
        .rstn_i(rstn_i),
        .active_i(loop_active),
        .flow_valid_i(store_flow || store_event),
        .flow_addr_i(store_event ? {9'h000, bus_i.data} : bus_i.addr),
        .flow_paged_i(store_event ? 1'b0 : bus_i.paged),
        .cmp_c_addr_i(cmp_c_addr_i),
        .cmp_c_paged_i(cmp_c_paged_i),
        .fifo_o(loop_fifo),
        .load_c_o(load_c_o),
        .load_c_addr_o(load_c_addr_o),
        .load_c_paged_o(load_c_paged_o)
    );

    assign fifo_o = loop_fifo;

    // Break requests; comparator C unavailable while it tracks loops
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            break_force_o <= 1'b0;
            break_tag_o <= 1'b0;
            end_trace_held_q <= 1'b0;
        end
        else
        begin
            end_trace_held_q <= run_end;
            break_force_o <= cpu_break_enable && module_enable && !breakpoint_kind_select &&
                             (run_end || (match_c && !repeat_loop_filter));
            break_tag_o <= cpu_break_enable && module_enable && breakpoint_kind_select &&
                           (run_end || (match_c && !repeat_loop_filter));
        end
    end

endmodule
`default_nettype wire

// >>> design/trace_ctrl_pkg.sv
package trace_ctrl_pkg;

    // Register indices; each byte address is four times the index
    localparam logic [7:0] CTRL_INDEX = 8'h0c;
    localparam logic [7:0] TRIG_INDEX = 8'h0d;
    localparam logic [7:0] STAT_INDEX = 8'h40;
    localparam logic [11:0] CTRL_ADDR = {2'h0, CTRL_INDEX, 2'h0};
    localparam logic [11:0] TRIG_ADDR = {2'h0, TRIG_INDEX, 2'h0};
    localparam logic [11:0] STAT_ADDR = {2'h0, STAT_INDEX, 2'h0};

    // Control register fields
    localparam int CTRL_EN_BIT = 7;
    localparam int CTRL_ARM_BIT = 6;
    localparam int CTRL_TAG_BIT = 5;
    localparam int CTRL_BRK_BIT = 4;
    localparam int CTRL_LOOP_BIT = 0;
    localparam logic [7:0] CTRL_RESET = 8'hc0;
    localparam logic [7:0] CTRL_WMASK = 8'hf1;

    // Trigger setup fields
    localparam int TRIG_OPC_BIT = 7;
    localparam int TRIG_BEGIN_BIT = 6;
    localparam int TRIG_MODE_LSB = 0;
    localparam logic [7:0] TRIG_RESET = 8'h00;
    localparam logic [7:0] TRIG_WMASK = 8'hcf;

    typedef enum logic [3:0] {
        MODE_A_ONLY = 4'h0,
        MODE_A_OR_B = 4'h1,
        MODE_A_THEN_B = 4'h2,
        MODE_EVENT_B = 4'h3,
        MODE_A_THEN_EVENT_B = 4'h4,
        MODE_A_AND_B = 4'h5,
        MODE_A_AND_NOT_B = 4'h6,
        MODE_INSIDE = 4'h7,
        MODE_OUTSIDE = 4'h8
    } trig_mode_e;

    typedef enum logic [1:0] {
        RUN_IDLE = 2'b00,
        RUN_WAIT_A = 2'b01,
        RUN_CAPTURE = 2'b11
    } run_state_e;

    // One bus cycle as seen by the comparators
    typedef struct packed {
        logic valid;
        logic [16:0] addr;
        logic [7:0] data;
        logic paged;
        logic executed;
        logic flow_change;
    } bus_cycle_s;

    // FIFO write request sent to the datapath
    typedef struct packed {
        logic write;
        logic [16:0] addr;
        logic paged;
    } fifo_write_s;

    localparam logic [16:0] ADDR_RESET = 17'h00000;

endpackage

// >>> design/trace_loop_track.sv
`timescale 1ns/1ps
`default_nettype none
module trace_loop_track
    import trace_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic active_i,
    input wire logic flow_valid_i,
    input wire logic [16:0] flow_addr_i,
    input wire logic flow_paged_i,
    input wire logic [16:0] cmp_c_addr_i,
    input wire logic cmp_c_paged_i,
    output fifo_write_s fifo_o,
    output logic load_c_o,
    output logic [16:0] load_c_addr_o,
    output logic load_c_paged_o
);

    logic repeat_hit;

    assign repeat_hit = active_i && (flow_addr_i == cmp_c_addr_i) &&
                        (flow_paged_i == cmp_c_paged_i);

    // Registered so the FIFO and comparator C see the same edge
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            fifo_o <= '0;
            load_c_o <= 1'b0;
            load_c_addr_o <= ADDR_RESET;
            load_c_paged_o <= 1'b0;
        end
        else
        begin
            fifo_o.write <= flow_valid_i && !repeat_hit;
            fifo_o.addr <= flow_addr_i;
            fifo_o.paged <= flow_paged_i;
            load_c_o <= flow_valid_i && active_i && !repeat_hit;
            load_c_addr_o <= flow_addr_i;
            load_c_paged_o <= flow_paged_i;
        end
    end

endmodule
`default_nettype wire

// >>> tb/cpu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
    import trace_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic break_force_i,
    input wire logic break_tag_i,
    output bus_cycle_s bus_o
);
    int force_seen = 0;
    int tag_seen = 0;
    initial bus_o = '0;
    always @(posedge clk_i)
    begin
        if (break_force_i === 1'b1)
            force_seen++;
        if (break_tag_i === 1'b1)
            tag_seen++;
    end
    // One bus cycle; afterwards the lines flip so stale values cannot match
    task automatic issue(input logic [16:0] a, input logic [7:0] d, input logic exec,
        input logic flow);
        @(posedge clk_i);
        bus_o <= {1'b1, a, d, 1'b0, exec, flow};
        @(posedge clk_i);
        bus_o <= {1'b0, ~a, ~d, 1'b1, ~exec, 1'b0};
    endtask
endmodule
`default_nettype wire

// >>> tb/debug_trace_control_trigger_bench.sv
`timescale 1ns/1ps
`default_nettype none
module debug_trace_control_trigger_bench
    import trace_ctrl_pkg::*;
;
    logic clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic etr = 1'b0;
    logic secure = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    bus_cycle_s bus;
    logic [16:0] cmp_a = 17'h0;
    logic [16:0] cmp_b = 17'h0;
    logic [16:0] cmp_c = 17'h0;
    logic [7:0] low_byte = 8'h0;
    logic brk_f;
    logic brk_t;
    logic trig;
    fifo_write_s fifo_w;
    logic load_c;
    logic [16:0] load_addr;
    logic load_paged;
    int err_total = 0;
    int check_count = 0;
    int seed;
    always #2 clk_i = ~clk_i;
    debug_trace_control_trigger dut_u (.clk_i(clk_i), .rstn_i(rstn_i),
        .end_trace_reset_i(etr), .secure_i(secure), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .bus_i(bus), .cmp_a_addr_i(cmp_a),
        .cmp_b_addr_i(cmp_b), .comparator_b_low_byte_i(low_byte), .cmp_c_addr_i(cmp_c),
        .cmp_c_paged_i(1'b0), .fifo_full_i(1'b0), .fifo_o(fifo_w), .load_c_o(load_c),
        .load_c_addr_o(load_addr), .load_c_paged_o(load_paged), .break_force_o(brk_f),
        .break_tag_o(brk_t),
        .triggered_o(trig));
    cpu_core_model core_u (.clk_i(clk_i), .break_force_i(brk_f), .break_tag_i(brk_t),
        .bus_o(bus));
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int n;
        @(posedge clk_i);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_i);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk_i);
            if (pready === 1'b1)
                break;
        end
        if (n == 20)
        begin
            err_total++;
            conclude();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        logic e;
        apb(1'b0, a, 32'h0, r, e);
    endtask
    task automatic wr(input logic [11:0] a, input logic [7:0] v);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, {24'h0, v}, r, e);
    endtask
    // Trigger setup, arm config, executed flag, expected trigger, force, tag
    logic [7:0] run_trg [4] = '{8'h80, 8'h00, 8'h00, 8'h00};
    logic [7:0] run_ctl [4] = '{8'hd0, 8'hd0, 8'hf0, 8'hc0};
    logic [3:0] run_exp [4] = '{4'h0, 4'he, 4'hd, 4'hc};
    initial
    begin
        logic [31:0] r;
        logic e;
        logic [7:0] v;
        logic hit;
        int f0;
        int t0;
        int n;
        seed = 32'h1dd3;
        cmp_b = 17'($random(seed));
        cmp_c = 17'($random(seed));
        low_byte = 8'($random(seed));
        repeat (3) @(posedge clk_i);
        rstn_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rd(CTRL_ADDR, r);
        chk(r, {24'h0, CTRL_RESET});
        wr(TRIG_ADDR, 8'h47);
        rd(TRIG_ADDR, r);
        chk(r, {24'h0, TRIG_RESET});
        apb(1'b0, 12'h3fc, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        wr(CTRL_ADDR, 8'h80);
        for (int i = 0; i < 12; i++)
        begin
            v = 8'($random(seed));
            wr(TRIG_ADDR, v);
            rd(TRIG_ADDR, r);
            chk(r, {24'h0, v & TRIG_WMASK});
        end
        for (int i = 0; i < 6; i++)
        begin
            v = 8'($random(seed)) & 8'hbf;
            wr(CTRL_ADDR, v);
            rd(CTRL_ADDR, r);
            chk(r, {24'h0, v & CTRL_WMASK});
        end
        secure <= 1'b1;
        repeat (4) @(posedge clk_i);
        wr(CTRL_ADDR, 8'h80);
        rd(CTRL_ADDR, r);
        chk({31'h0, r[CTRL_EN_BIT]}, 32'h0);
        secure <= 1'b0;
        repeat (4) @(posedge clk_i);
        wr(CTRL_ADDR, 8'h80);
        wr(TRIG_ADDR, 8'h05);
        wr(CTRL_ADDR, 8'hf1);
        @(posedge clk_i);
        etr <= 1'b1;
        @(posedge clk_i);
        etr <= 1'b0;
        repeat (3) @(posedge clk_i);
        rd(CTRL_ADDR, r);
        chk(r, 32'ha1);
        rd(TRIG_ADDR, r);
        chk(r, 32'h05);
        for (int k = 0; k < 4; k++)
        begin
            wr(CTRL_ADDR, 8'h80);
            wr(TRIG_ADDR, run_trg[k]);
            cmp_a <= 17'($random(seed));
            wr(CTRL_ADDR, run_ctl[k]);
            f0 = core_u.force_seen;
            t0 = core_u.tag_seen;
            core_u.issue(cmp_a, 8'($random(seed)), run_exp[k][3], 1'b0);
            // The trigger flag drops once the run is idle, so watch every cycle
            hit = 1'b0;
            for (n = 0; n < 8; n++)
            begin
                @(posedge clk_i);
                if (trig === 1'b1)
                    hit = 1'b1;
            end
            chk({31'h0, hit}, {31'h0, run_exp[k][2]});
            chk(core_u.force_seen - f0, {31'h0, run_exp[k][1]});
            chk(core_u.tag_seen - t0, {31'h0, run_exp[k][0]});
        end
        wr(CTRL_ADDR, 8'h80);
        wr(TRIG_ADDR, 8'h00);
        cmp_a <= ~cmp_c;
        wr(CTRL_ADDR, 8'hc1);
        core_u.issue(cmp_c, 8'h00, 1'b1, 1'b1);
        @(posedge clk_i);
        chk({31'h0, fifo_w.write}, 32'h0);
        chk({31'h0, load_c}, 32'h0);
        core_u.issue(cmp_c ^ 17'h00001, 8'h00, 1'b1, 1'b1);
        @(posedge clk_i);
        chk({30'h0, fifo_w.write, load_c}, 32'h3);
        chk({15'h0, fifo_w.addr}, {15'h0, cmp_c ^ 17'h00001});
        chk({15'h0, load_addr}, {15'h0, cmp_c ^ 17'h00001});
        chk({30'h0, fifo_w.paged, load_paged}, 32'h0);
        conclude();
    end
endmodule
`default_nettype wire

// >>> tb/trace_ctrl_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module trace_ctrl_checker
    import trace_ctrl_pkg::*;
(
    input wire logic clk_i,
    input wire logic rstn_i,
    input wire logic secure_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    input wire fifo_write_s fifo_o,
    input wire logic load_c_o,
    input wire logic [16:0] load_c_addr_o,
    input wire logic load_c_paged_o,
    input wire logic break_force_o,
    input wire logic break_tag_o
);
    logic acc;
    logic mapped;
    assign acc = psel_i && penable_i;
    assign mapped = paddr_i == CTRL_ADDR || paddr_i == TRIG_ADDR || paddr_i == STAT_ADDR;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rstn_i);
    a_ready_high:
        assert property (acc |-> pready_o) else $error("pready low in access phase");
    a_unmapped_err:
        assert property (acc && !mapped |-> pslverr_o) else $error("unmapped access not refused");
    a_mapped_ok:
        assert property (acc && mapped |-> !pslverr_o) else $error("mapped access refused");
    // Four cycles covers the two-stage synchroniser plus the register update
    a_secure_en_zero:
        assert property (secure_i [*4] ##0 (acc && !pwrite_i && paddr_i == CTRL_ADDR)
            |-> !prdata_o[CTRL_EN_BIT]) else $error("enable visible while secured");
    a_break_one_kind:
        assert property (!(break_force_o && break_tag_o)) else $error("force and tag together");
    a_force_pulse:
        assert property (break_force_o |=> !break_force_o) else $error("force request too long");
    a_tag_pulse:
        assert property (break_tag_o |=> !break_tag_o) else $error("tag request too long");
    a_load_with_write:
        assert property (load_c_o |-> fifo_o.write && load_c_addr_o == fifo_o.addr
            && load_c_paged_o == fifo_o.paged) else $error("loaded address differs from stored");
    a_load_pulse:
        assert property (load_c_o |=> !load_c_o) else $error("load pulse too long");
    c_ctrl_write: cover property (acc && pwrite_i && paddr_i == CTRL_ADDR);
    c_force: cover property (break_force_o);
    c_tag: cover property (break_tag_o);
endmodule
bind debug_trace_control_trigger trace_ctrl_checker chk_u (.clk_i(clk_i), .rstn_i(rstn_i),
    .secure_i(secure_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
    .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .fifo_o(fifo_o), .load_c_o(load_c_o), .load_c_addr_o(load_c_addr_o),
    .load_c_paged_o(load_c_paged_o), .break_force_o(break_force_o), .break_tag_o(break_tag_o));
`default_nettype wire
